// *** hw/ata_pkg.sv ***
// Shared constants for the card end and the host end of the ATA register link.
// Assumes a 250 MHz clock on both ends.
package ata_pkg;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_MHZ = 250;
    localparam int BUSY_NS = 400;
    localparam int BUSY_CYC = BUSY_NS * CLK_MHZ / 1000;
    localparam int XFER2_US = 700;
    localparam int XFER2_CYC = XFER2_US * CLK_MHZ;
    localparam int XFER3_MS = 20;
    localparam int XFER3_CYC = XFER3_MS * 1000 * CLK_MHZ;
    // ----------------------------------------
    // Link register indices
    // ----------------------------------------
    localparam logic [3:0] REG_DATA = 4'h0;
    localparam logic [3:0] REG_ERR = 4'h1;
    localparam logic [3:0] REG_FEAT = 4'h1;
    localparam logic [3:0] REG_CNT = 4'h2;
    localparam logic [3:0] REG_SNUM = 4'h3;
    localparam logic [3:0] REG_CYLL = 4'h4;
    localparam logic [3:0] REG_CYLH = 4'h5;
    localparam logic [3:0] REG_DH = 4'h6;
    localparam logic [3:0] REG_STAT = 4'h7;
    localparam logic [3:0] REG_CMD = 4'h7;
    localparam logic [3:0] REG_ALT = 4'hE;
    localparam logic [3:0] REG_CTRL = 4'hE;
    // ----------------------------------------
    // Fields and codes
    // ----------------------------------------
    localparam int ST_BSY = 7;
    localparam int ST_RDY = 6;
    localparam int ST_DSC = 4;
    localparam int ST_DATA_REQ = 3;
    localparam int ST_ERR = 0;
    localparam int DC_NIEN = 1;
    localparam int DC_SRST = 2;
    localparam int DH_LBA = 6;
    localparam logic [7:0] CMD_DIAG = 8'h90;
    localparam logic [7:0] CMD_IDENT = 8'hEC;
    localparam logic [7:0] CMD_READ = 8'h20;
    localparam logic [7:0] CMD_SETF = 8'hEF;
    localparam logic [7:0] CMD_WRITE = 8'h30;
    localparam logic [7:0] DIAG_OK = 8'h00;
    localparam logic [7:0] DIAG_FMT = 8'h02;
    localparam logic [7:0] DIAG_BUF = 8'h03;
    localparam logic [7:0] DIAG_ECC = 8'h04;
    localparam logic [7:0] DIAG_CPU = 8'h05;
    localparam logic [7:0] DIAG_SLAVE = 8'h80;
    localparam logic [7:0] FEAT_8BIT = 8'h01;
    localparam logic [7:0] FEAT_16BIT = 8'h81;
    localparam logic [7:0] ERR_ABRT = 8'h04;
    localparam logic [7:0] ERR_UNC = 8'h40;
    localparam logic [7:0] ERR_IDNF = 8'h10;
    localparam logic [15:0] ID_CONFIG = 16'h1234; // Arbitrary value
    localparam int SEC_WORDS = 256;
    localparam logic [8:0] LAST_WORD = 9'd255;
    localparam logic [8:0] LAST_BYTE = 9'd511;
    // ----------------------------------------
    // Host controller Wishbone map
    // ----------------------------------------
    localparam logic [7:0] WB_CMD = 8'h00;
    localparam logic [7:0] WB_ADDR = 8'h04;
    localparam logic [7:0] WB_CNT = 8'h08;
    localparam logic [7:0] WB_STAT = 8'h0C;
    localparam logic [7:0] WB_DATA = 8'h10;
endpackage

// *** hw/ata_link_if.sv ***
// Parallel register link between a host and the card.
// Assumes both ends run on the same clock; strobes last one cycle.
`timescale 1ns/1ps
interface ata_link_if (
    input wire logic clk_i
);
    logic [3:0] addr;
    logic wr;
    logic rd;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic interrupt_request_line;
    modport dev (input addr, input wr, input rd, input wdata, output rdata, output interrupt_request_line);
    modport host (output addr, output wr, output rd, output wdata, input rdata, input interrupt_request_line);
endinterface

// *** hw/card_end.sv ***
// Card end: ATA command block, status, data register and sector buffer.
// Assumes a host that honours the busy flag and one-cycle link strobes.
//
// Register access over Wishbone and the placing of the registers were decided locally.
`timescale 1ns/1ps
// What this block and the host end do
// - Host loads parameters before command code
// - Host writes commands only when not busy
// - Class one command raises busy within 400ns
// - Class two: busy, data request, busy clears
// - Class three data request within 20ms
// - Diagnostic leaves result code in error register
// - Identify sets data request, host reads words
// - Read returns count sectors, request per sector
// - Sector count zero means 256 sectors
// - Address holds last read or failing sector
// - Host polls data request, moves whole sector
// - Host abandons read on error flag
// - Host waits ready, reads error register
// - Set features selects 8-bit data width
// - Write takes count sectors, request per sector
// - Write error stops at failing sector address
// - Host abandons write on error flag
// - Polling host disables card interrupts first
// - Status read clears interrupt, alternate does not
// - Sector count shows sectors still needed
// - LBA split across address registers
module card_end #(
    parameter int WAIT_CYC = ata_pkg::XFER2_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    ata_link_if.dev link,
    input wire logic [7:0] diag_code_i,
    input wire logic media_fault_i,
    output logic xfer8_o,
    output logic busy_o
);
    import ata_pkg::*;

    typedef enum logic [1:0] {S_IDLE, S_WAIT, S_XFER} state_t;
    typedef struct packed {
        state_t st;
        logic busy;
        logic data_request_flag;
        logic err;
        logic ipend;
        logic nien;
        logic x8;
        logic prog;
        logic [7:0] errc;
        logic [7:0] feat;
        logic [7:0] cnt;
        logic [7:0] snum;
        logic [7:0] cyll;
        logic [7:0] cylh;
        logic [7:0] dh;
        logic [7:0] cmd;
        logic [8:0] left;
        logic [8:0] widx;
        logic [31:0] tmr;
        logic [15:0] rdat;
    } card_t;

    card_t r_q, r_d;
    logic [7:0] buf_lo [SEC_WORDS];
    logic [7:0] buf_hi [SEC_WORDS];
    logic [27:0] cur, nxt;
    logic [7:0] wi;
    logic [7:0] stat;
    logic [15:0] word;
    logic last, data_rd, data_wr;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [27:0] next_addr(input logic [27:0] a, input logic lba);
        next_addr = lba ? a + 28'h1 : {a[27:8], a[7:0] + 8'h1};
    endfunction

    function automatic logic [15:0] ident_word(input logic [7:0] i);
        ident_word = (i == 8'h00) ? ID_CONFIG : {8'h00, i};
    endfunction

    assign cur = {r_q.dh[3:0], r_q.cylh, r_q.cyll, r_q.snum};
    assign nxt = next_addr(cur, r_q.dh[DH_LBA]);
    assign wi = r_q.x8 ? r_q.widx[8:1] : r_q.widx[7:0];
    assign last = r_q.widx == (r_q.x8 ? LAST_BYTE : LAST_WORD);
    assign word = (r_q.cmd == CMD_IDENT) ? ident_word(wi) : {buf_hi[wi], buf_lo[wi]};
    assign data_rd = link.rd && link.addr == REG_DATA && r_q.st == S_XFER && r_q.cmd != CMD_WRITE;
    assign data_wr = link.wr && link.addr == REG_DATA && r_q.st == S_XFER && r_q.cmd == CMD_WRITE;

    always_comb begin
        stat = 8'h00;
        stat[ST_BSY] = r_q.busy;
        stat[ST_RDY] = ~r_q.busy;
        stat[ST_DSC] = ~r_q.busy;
        stat[ST_DATA_REQ] = r_q.data_request_flag;
        stat[ST_ERR] = r_q.err;
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        r_d = r_q;
        if (link.rd && link.addr == REG_STAT) begin
            r_d.ipend = 1'b0;
        end
        if (link.rd) begin
            if (link.addr == REG_DATA) begin
                if (r_q.x8) begin
                    r_d.rdat = {8'h00, r_q.widx[0] ? word[15:8] : word[7:0]};
                end else begin
                    r_d.rdat = word;
                end
            end else if (link.addr == REG_ERR) begin
                r_d.rdat = {8'h00, r_q.errc};
            end else if (link.addr == REG_CNT) begin
                r_d.rdat = {8'h00, r_q.cnt};
            end else if (link.addr == REG_SNUM) begin
                r_d.rdat = {8'h00, r_q.snum};
            end else if (link.addr == REG_CYLL) begin
                r_d.rdat = {8'h00, r_q.cyll};
            end else if (link.addr == REG_CYLH) begin
                r_d.rdat = {8'h00, r_q.cylh};
            end else if (link.addr == REG_DH) begin
                r_d.rdat = {8'h00, r_q.dh};
            end else if (link.addr == REG_STAT || link.addr == REG_ALT) begin
                r_d.rdat = {8'h00, stat};
            end else begin
                r_d.rdat = 16'h0000;
            end
        end
        if (link.wr && !r_q.busy) begin
            if (link.addr == REG_FEAT) begin
                r_d.feat = link.wdata[7:0];
            end else if (link.addr == REG_CNT) begin
                r_d.cnt = link.wdata[7:0];
            end else if (link.addr == REG_SNUM) begin
                r_d.snum = link.wdata[7:0];
            end else if (link.addr == REG_CYLL) begin
                r_d.cyll = link.wdata[7:0];
            end else if (link.addr == REG_CYLH) begin
                r_d.cylh = link.wdata[7:0];
            end else if (link.addr == REG_DH) begin
                r_d.dh = link.wdata[7:0];
            end else if (link.addr == REG_CMD && r_q.st == S_IDLE) begin
                r_d.cmd = link.wdata[7:0];
                r_d.busy = 1'b1;
                r_d.err = 1'b0;
                r_d.errc = 8'h00;
                r_d.data_request_flag = 1'b0;
                r_d.prog = 1'b0;
                r_d.tmr = 32'h0;
                r_d.widx = 9'h000;
                r_d.left = (r_q.cnt == 8'h00) ? 9'd256 : {1'b0, r_q.cnt};
                r_d.st = S_WAIT;
            end
        end
        case (r_q.st)
            S_WAIT: begin
                r_d.tmr = r_q.tmr + 32'h1;
                if (r_q.tmr >= 32'(WAIT_CYC - 1)) begin
                    r_d.tmr = 32'h0;
                    r_d.busy = 1'b0;
                    r_d.ipend = 1'b1;
                    r_d.st = S_IDLE;
                    if (r_q.cmd == CMD_DIAG) begin
                        r_d.errc = diag_code_i;
                    end else if (r_q.cmd == CMD_SETF) begin
                        if (r_q.feat == FEAT_8BIT) begin
                            r_d.x8 = 1'b1;
                        end else if (r_q.feat == FEAT_16BIT) begin
                            r_d.x8 = 1'b0;
                        end else begin
                            r_d.err = 1'b1;
                            r_d.errc = ERR_ABRT;
                        end
                    end else if (r_q.cmd == CMD_IDENT) begin
                        r_d.left = 9'd1;
                        r_d.data_request_flag = 1'b1;
                        r_d.st = S_XFER;
                    end else if (r_q.cmd == CMD_READ || r_q.cmd == CMD_WRITE) begin
                        if (media_fault_i) begin
                            r_d.err = 1'b1;
                            r_d.errc = (r_q.cmd == CMD_READ) ? ERR_UNC : ERR_IDNF;
                        end else if (r_q.prog) begin
                            r_d.prog = 1'b0;
                            r_d.cnt = r_q.cnt - 8'h1;
                            r_d.left = r_q.left - 9'h1;
                            if (r_q.left != 9'd1) begin
                                {r_d.dh[3:0], r_d.cylh, r_d.cyll, r_d.snum} = nxt;
                                r_d.data_request_flag = 1'b1;
                                r_d.st = S_XFER;
                            end
                        end else begin
                            r_d.data_request_flag = 1'b1;
                            r_d.st = S_XFER;
                        end
                    end else begin
                        r_d.err = 1'b1;
                        r_d.errc = ERR_ABRT;
                    end
                end
            end
            S_XFER: begin
                if (data_rd || data_wr) begin
                    r_d.widx = r_q.widx + 9'h1;
                    if (last) begin
                        r_d.widx = 9'h000;
                        r_d.data_request_flag = 1'b0;
                        r_d.busy = 1'b1;
                        r_d.st = S_WAIT;
                        if (r_q.cmd == CMD_WRITE) begin
                            r_d.prog = 1'b1;
                        end else begin
                            r_d.left = r_q.left - 9'h1;
                            if (r_q.cmd == CMD_READ) begin
                                r_d.cnt = r_q.cnt - 8'h1;
                            end
                            if (r_q.left == 9'd1) begin
                                r_d.busy = 1'b0;
                                r_d.ipend = 1'b1;
                                r_d.st = S_IDLE;
                            end else begin
                                {r_d.dh[3:0], r_d.cylh, r_d.cyll, r_d.snum} = nxt;
                            end
                        end
                    end
                end
            end
            default: begin
            end
        endcase
        if (link.wr && link.addr == REG_CTRL) begin
            r_d.nien = link.wdata[DC_NIEN];
            if (link.wdata[DC_SRST]) begin
                r_d.st = S_IDLE;
                r_d.busy = 1'b0;
                r_d.data_request_flag = 1'b0;
                r_d.err = 1'b0;
                r_d.errc = 8'h00;
            end
        end
    end

    // ----------------------------------------
    // Registers and sector buffer
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (data_wr) begin
            if (!r_q.x8 || !r_q.widx[0]) begin
                buf_lo[wi] <= link.wdata[7:0];
            end
            if (!r_q.x8) begin
                buf_hi[wi] <= link.wdata[15:8];
            end else if (r_q.widx[0]) begin
                buf_hi[wi] <= link.wdata[7:0];
            end
        end
    end

    assign link.rdata = r_q.rdat;
    assign link.interrupt_request_line = r_q.ipend & ~r_q.nien;
    assign xfer8_o = r_q.x8;
    assign busy_o = r_q.busy;
endmodule

// *** hw/host_end.sv ***
// Host end: Wishbone-controlled sequencer that issues ATA commands by polling.
// Assumes a classic Wishbone master and the card end on the same clock.
`timescale 1ns/1ps
module host_end (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    ata_link_if.host link
);
    import ata_pkg::*;

    typedef enum logic [2:0] {P_IDLE, P_PRE, P_SETUP, P_RUN, P_XFER, P_ERR} phase_t;
    typedef struct packed {
        phase_t ph;
        logic [2:0] step;
        logic rd;
        logic rdv;
        logic wr;
        logic ack;
        logic x8;
        logic err;
        logic [3:0] addr;
        logic [15:0] wdat;
        logic [9:0] words;
        logic [7:0] cmd;
        logic [7:0] cnt;
        logic [7:0] feat;
        logic [7:0] errc;
        logic [7:0] dstat;
        logic [28:0] adr;
        logic [31:0] dout;
    } host_t;

    host_t r_q, r_d;
    logic req, dat, free;

    function automatic logic [31:0] lanes(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
        for (int i = 0; i < 4; i++) begin
            lanes[8*i +: 8] = s[i] ? n[8*i +: 8] : o[8*i +: 8];
        end
    endfunction

    assign req = wb_cyc_i & wb_stb_i & ~r_q.ack;
    assign dat = req && wb_adr_i == WB_DATA;
    assign free = ~r_q.rd & ~r_q.rdv;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        logic [31:0] tmp;
        tmp = 32'h0;
        r_d = r_q;
        r_d.rd = 1'b0;
        r_d.wr = 1'b0;
        r_d.ack = 1'b0;
        r_d.rdv = r_q.rd;
        if (req && !dat) begin
            r_d.ack = 1'b1;
            if (wb_adr_i == WB_CMD) begin
                r_d.dout = {24'h0, r_q.cmd};
                if (wb_we_i && wb_sel_i[0] && r_q.ph == P_IDLE) begin
                    r_d.cmd = wb_dat_i[7:0];
                    r_d.err = 1'b0;
                    r_d.errc = 8'h00;
                    r_d.ph = P_PRE;
                end
            end else if (wb_adr_i == WB_ADDR) begin
                r_d.dout = {3'b000, r_q.adr};
                tmp = lanes({3'b000, r_q.adr}, wb_dat_i, wb_sel_i);
                if (wb_we_i && r_q.ph == P_IDLE) begin
                    r_d.adr = tmp[28:0];
                end
            end else if (wb_adr_i == WB_CNT) begin
                r_d.dout = {16'h0, r_q.feat, r_q.cnt};
                tmp = lanes({16'h0, r_q.feat, r_q.cnt}, wb_dat_i, wb_sel_i);
                if (wb_we_i && r_q.ph == P_IDLE) begin
                    r_d.cnt = tmp[7:0];
                    r_d.feat = tmp[15:8];
                end
            end else if (wb_adr_i == WB_STAT) begin
                r_d.dout = {8'h00, r_q.dstat, r_q.errc, 4'h0, r_q.x8, r_q.ph == P_XFER, r_q.err, r_q.ph != P_IDLE};
            end else begin
                r_d.dout = 32'h0;
            end
        end else if (dat && r_q.ph == P_IDLE) begin
            r_d.ack = 1'b1;
            r_d.dout = 32'h0;
        end
        case (r_q.ph)
            P_PRE: begin
                if (r_q.rdv) begin
                    r_d.dstat = link.rdata[7:0];
                    if (!link.rdata[ST_BSY]) begin
                        r_d.step = 3'h0;
                        r_d.ph = P_SETUP;
                    end
                end else if (free) begin
                    r_d.rd = 1'b1;
                    r_d.addr = REG_ALT;
                end
            end
            P_SETUP: begin
                r_d.wr = 1'b1;
                r_d.step = r_q.step + 3'h1;
                r_d.wdat = 16'h0;
                case (r_q.step)
                    3'h0: begin
                        r_d.addr = REG_CTRL;
                        r_d.wdat[DC_NIEN] = 1'b1;
                    end
                    3'h1: begin
                        r_d.addr = REG_FEAT;
                        r_d.wdat = {8'h00, r_q.feat};
                    end
                    3'h2: begin
                        r_d.addr = REG_CNT;
                        r_d.wdat = {8'h00, r_q.cnt};
                    end
                    3'h3: begin
                        r_d.addr = REG_SNUM;
                        r_d.wdat = {8'h00, r_q.adr[7:0]};
                    end
                    3'h4: begin
                        r_d.addr = REG_CYLL;
                        r_d.wdat = {8'h00, r_q.adr[15:8]};
                    end
                    3'h5: begin
                        r_d.addr = REG_CYLH;
                        r_d.wdat = {8'h00, r_q.adr[23:16]};
                    end
                    3'h6: begin
                        r_d.addr = REG_DH;
                        r_d.wdat = {8'h00, 1'b1, r_q.adr[28], 2'b10, r_q.adr[27:24]};
                    end
                    default: begin
                        r_d.addr = REG_CMD;
                        r_d.wdat = {8'h00, r_q.cmd};
                        r_d.ph = P_RUN;
                    end
                endcase
            end
            P_RUN: begin
                if (r_q.rdv) begin
                    r_d.dstat = link.rdata[7:0];
                    if (!link.rdata[ST_BSY]) begin
                        if (link.rdata[ST_ERR]) begin
                            r_d.ph = P_ERR;
                        end else if (link.rdata[ST_DATA_REQ]) begin
                            r_d.words = 10'h000;
                            r_d.ph = P_XFER;
                        end else if (link.rdata[ST_RDY] && r_q.cmd == CMD_DIAG) begin
                            r_d.ph = P_ERR;
                        end else if (link.rdata[ST_RDY]) begin
                            r_d.ph = P_IDLE;
                            if (r_q.cmd == CMD_SETF && r_q.feat == FEAT_8BIT) begin
                                r_d.x8 = 1'b1;
                            end else if (r_q.cmd == CMD_SETF && r_q.feat == FEAT_16BIT) begin
                                r_d.x8 = 1'b0;
                            end
                        end
                    end
                end else if (free) begin
                    r_d.rd = 1'b1;
                    r_d.addr = REG_ALT;
                end
            end
            P_ERR: begin
                if (r_q.rdv) begin
                    r_d.errc = link.rdata[7:0];
                    r_d.err = r_q.cmd != CMD_DIAG;
                    r_d.ph = P_IDLE;
                end else if (free) begin
                    r_d.rd = 1'b1;
                    r_d.addr = REG_ERR;
                end
            end
            P_XFER: begin
                if (r_q.rdv) begin
                    r_d.ack = 1'b1;
                    r_d.dout = {16'h0, r_q.x8 ? {8'h00, link.rdata[7:0]} : link.rdata};
                    r_d.words = r_q.words + 10'h1;
                end else if (dat && free) begin
                    r_d.addr = REG_DATA;
                    if (wb_we_i) begin
                        r_d.wr = 1'b1;
                        r_d.wdat = r_q.x8 ? {8'h00, wb_dat_i[7:0]} : wb_dat_i[15:0];
                        r_d.ack = 1'b1;
                        r_d.words = r_q.words + 10'h1;
                    end else begin
                        r_d.rd = 1'b1;
                    end
                end
                if (r_d.words == (r_q.x8 ? 10'd512 : 10'd256)) begin
                    r_d.ph = P_RUN;
                end
            end
            default: begin
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    assign link.addr = r_q.addr;
    assign link.wr = r_q.wr;
    assign link.rd = r_q.rd;
    assign link.wdata = r_q.wdat;
    assign wb_ack_o = r_q.ack;
    assign wb_dat_o = r_q.dout;
endmodule

// *** tb/ata_link_chk.sv ***
// Checker: assertions on the register link between host end and card end.
// Assumes the bench instantiates it beside the link interface.
`timescale 1ns/1ps
module ata_link_chk (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [3:0] addr,
    input wire logic wr,
    input wire logic rd,
    input wire logic [15:0] wdata,
    input wire logic [15:0] rdata,
    input wire logic interrupt_request_line,
    input wire logic busy_o
);
    import ata_pkg::*;
    localparam int BMAX = 100;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    sequence cmd_s;
        wr && addr == REG_CMD;
    endsequence
    AST_ONE_STROBE: assert property (!(wr && rd)) else $error("strobes clash");
    AST_RDATA_HOLD: assert property (!$past(rd) |-> $stable(rdata)) else $error("rdata moved");
    AST_LOAD_FIRST: assert property (cmd_s |-> $past(wr) && $past(addr) == REG_DH) else $error("no load");
    AST_IDLE_CMD: assert property (cmd_s |-> !busy_o) else $error("command while busy");
    AST_BUSY_SET: assert property (cmd_s |=> busy_o) else $error("busy late");
    AST_BUSY_HOLD: assert property ($rose(busy_o) |-> busy_o [*8]) else $error("busy short");
    AST_BUSY_END: assert property ($rose(busy_o) |-> ##[1:BMAX] !busy_o) else $error("busy long");
    AST_IRQ_OFF: assert property (!interrupt_request_line) else $error("interrupt seen");
    AST_NIEN_SET: assert property (wr && addr == REG_CTRL |-> wdata[DC_NIEN]) else $error("irq on");
endmodule

// *** tb/ata_pio_command_sequencer_test.sv ***
// Testbench: host end and card end joined by the link, driven over Wishbone.
// Assumes the card wait is shortened to 20 cycles.
`timescale 1ns/1ps
module ata_pio_command_sequencer_test;
    import ata_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0;
    logic [31:0] rdat;
    logic ack;
    logic [7:0] dcode = 8'h00;
    logic fault = 1'b0;
    logic x8;
    logic busy;
    logic [31:0] q;
    int num_errors = 0;
    int checks = 0;
    ata_link_if link (.clk_i(clk_i));
    card_end #(.WAIT_CYC(20)) card_end_inst (.clk_i(clk_i), .rst_i(rst_i), .link(link), .diag_code_i(dcode),
        .media_fault_i(fault), .xfer8_o(x8), .busy_o(busy));
    host_end host_end_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .link(link));
    ata_link_chk ata_link_chk_inst (.clk_i(clk_i), .rst_i(rst_i), .addr(link.addr), .wr(link.wr), .rd(link.rd),
        .wdata(link.wdata), .rdata(link.rdata), .interrupt_request_line(link.interrupt_request_line),
        .busy_o(busy));
    initial begin
        forever #2 clk_i = ~clk_i;
    end
    task automatic complete_run();
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do begin
            @(negedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (ack !== 1'b1) begin
            num_errors++;
            complete_run();
        end
        r = rdat;
        @(posedge clk_i);
        cyc <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic poll(input int b, input logic v);
        int n;
        n = 0;
        do begin
            wb(1'b0, WB_STAT, 32'h0, q);
            n++;
        end while (q[b] !== v && n < 200);
        if (q[b] !== v) begin
            num_errors++;
            complete_run();
        end
    endtask
    task automatic cmd(input logic [7:0] c);
        wb(1'b1, WB_CMD, {24'h0, c}, q);
    endtask
    task automatic xfer(input int ns, input logic w, input logic idn);
        logic [15:0] e;
        for (int s = 0; s < ns; s++) begin
            poll(2, 1'b1);
            for (int i = 0; i < 256; i++) begin
                e = idn ? (i == 0 ? ID_CONFIG : 16'(i)) : 16'h5A00 + 16'(i);
                wb(w, WB_DATA, {16'h0, e}, q);
                if (!w) chk("data word", {16'h0, e}, {16'h0, q[15:0]});
            end
        end
    endtask
    task automatic t_diag();
        logic [7:0] codes [6] = '{DIAG_OK, DIAG_FMT, DIAG_BUF, DIAG_ECC, DIAG_CPU, DIAG_SLAVE};
        foreach (codes[k]) begin
            dcode <= codes[k];
            cmd(CMD_DIAG);
            poll(0, 1'b0);
            chk("diag code", {24'h0, codes[k]}, {24'h0, q[15:8]});
        end
    endtask
    task automatic t_feat();
        wb(1'b1, WB_CNT, {16'h0, FEAT_8BIT, 8'h01}, q);
        cmd(CMD_SETF);
        poll(0, 1'b0);
        chk("8-bit mode", 32'h1, {31'h0, x8});
        wb(1'b1, WB_CNT, {16'h0, FEAT_16BIT, 8'h02}, q);
        cmd(CMD_SETF);
        poll(0, 1'b0);
        chk("16-bit mode", 32'h0, {31'h0, x8});
    endtask
    task automatic t_rw();
        wb(1'b1, WB_ADDR, 32'h1000_0040, q);
        cmd(CMD_WRITE);
        xfer(2, 1'b1, 1'b0);
        poll(0, 1'b0);
        chk("write error", 32'h0, {31'h0, q[1]});
        cmd(CMD_READ);
        xfer(2, 1'b0, 1'b0);
        poll(0, 1'b0);
        chk("read error", 32'h0, {31'h0, q[1]});
        cmd(CMD_IDENT);
        xfer(1, 1'b0, 1'b1);
        poll(0, 1'b0);
    endtask
    task automatic t_fault();
        wb(1'b1, WB_CNT, 32'h3, q);
        cmd(CMD_WRITE);
        xfer(1, 1'b1, 1'b0);
        fault <= 1'b1;
        poll(0, 1'b0);
        chk("write fault", {24'h0, ERR_IDNF}, {24'h0, q[15:8]});
        cmd(CMD_READ);
        poll(0, 1'b0);
        chk("read fault", {24'h0, ERR_UNC}, {24'h0, q[15:8]});
        fault <= 1'b0;
    endtask
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(1'b0, 8'h20, 32'h0, q);
        chk("unmapped read", 32'h0, q);
        wb(1'b1, WB_CNT, 32'h2, q);
        t_diag();
        t_feat();
        t_rw();
        t_fault();
        complete_run();
    end
endmodule
